// *** rtl/hps_fifo.sv ***
module hps_fifo #(
   parameter int W = 18,
   parameter int D = 4
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i,
   // fill level
   output logic [$clog2(D):0] count_o
);

   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_r != D[AW:0]);
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem[rptr_r];
   assign count_o = cnt_r;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage has no reset; only the pointers and the count need a defined state
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= (wptr_r == AW'(D - 1)) ? '0 : wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r <= (rptr_r == AW'(D - 1)) ? '0 : rptr_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

endmodule

// *** rtl/hps_map.svh ***
`ifndef HPS_MAP_SVH
`define HPS_MAP_SVH

// register indices; byte address is four times the index
`define HPS_IDX_RATIO 8'hA0
`define HPS_IDX_ACL 8'hA1
`define HPS_IDX_GCTL 8'hA2
`define HPS_IDX_STAT 8'hA3
`define HPS_ADDR(idx) ({22'h000000, idx, 2'h0})

// field positions
`define HPS_RATIO_F 5:0
`define HPS_ACL_F 5:0
`define HPS_GCTL_CPF 7:6
`define HPS_GCTL_LPF 5:4
`define HPS_GCTL_DBL 3
`define HPS_GCTL_SH 2:0

// reset values
`define HPS_RST_RATIO 6'h01
`define HPS_RST_ACL 6'h00
`define HPS_RST_GCTL 8'h00

// structure sizes
`define HPS_FIFO_DEPTH 4
`define HPS_HIST_DEPTH 128

`endif

// *** rtl/hps_pkg.sv ***
package hps_pkg;

   // one video sample, luma and chroma, with line markers
   typedef struct packed {
      logic sol;
      logic eol;
      logic [7:0] y;
      logic [7:0] c;
   } hps_pix_t;

   // prefilter select codes
   typedef enum logic [1:0] {
      HPS_PF_BYPASS = 2'h0,
      HPS_PF_121 = 2'h1,
      HPS_PF_WIDE = 2'h2,
      HPS_PF_12221 = 2'h3
   } hps_pf_t;

   // one history entry: running prefix sums and filtered samples
   typedef struct packed {
      logic [15:0] psum_y;
      logic [15:0] psum_c;
      logic [7:0] fy;
      logic [7:0] fc;
   } hps_hist_t;

   // state of the prescaler apart from the history memory and the output fifo
   typedef struct packed {
      logic [5:0] ratio;
      logic [5:0] acl;
      logic [7:0] gctl;
      logic wr_pend;
      logic [1:0] wr_sel;
      logic [31:0] rdata;
      logic [6:0][7:0] taps_y;
      logic [6:0][7:0] taps_c;
      logic [6:0] wptr;
      logic [15:0] psum_y;
      logic [15:0] psum_c;
      logic [5:0] grp_cnt;
      logic first_pend;
      logic in_line;
      logic [7:0] first_y;
      logic [7:0] first_c;
   } hps_state_t;

endpackage

// *** rtl/hps_prescaler.sv ***
// How it works
// [RULE_01] software keeps the decimation ratio between 1 and 63, never zero
// [RULE_02] accumulation gain is (double+1) times length plus (1 minus double)
// [RULE_03] a three-bit shift divides the sum by 1 down to 1/128
// [RULE_04] software should pick windows whose gain is a power of two
// [RULE_05] otherwise shift keeps overall gain at most one; gain stage corrects
// [RULE_06] software keeps averaging length below twice the decimation ratio
// [RULE_07] contrast and saturation are floor(64 * 2^shift / gain) then
// [RULE_08] luma and chroma share timing and ratio, each has its own prefilter
// [RULE_09] first and last output pixel of a line are raw source samples
// [RULE_10] prefilter codes: bypass, 1 2 1, wide luma/chroma kernel, 1 2 2 2 1
// [RULE_11] chroma prefilter select bits 7:6, luma bits 5:4 of gain control
// [RULE_12] recommended ratio, length, weight and shift sets are advisory
// [RULE_13] other settings are allowed if the gain stage compensates them
// [RULE_14] ratio and length may stray from formulas; fine scaler absorbs it
// [RULE_15] double weighting: ends weigh one, inner samples two; bit 3
// [RULE_16] six-bit decimation ratio in bits 5:0 of the ratio register
// [RULE_17] six-bit averaging length in bits 5:0, window of length+1 samples
// [RULE_18] one output per ratio input samples, weighted window sum then shift
`include "hps_map.svh"

module hps_prescaler (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // decoded sample stream in
   input wire logic in_valid_i,
   input wire hps_pkg::hps_pix_t in_pix_i,
   output logic in_ready_o,
   // prescaled stream out
   output logic out_valid_o,
   output hps_pkg::hps_pix_t out_pix_o,
   input wire logic out_ready_i
);

   hps_pkg::hps_state_t s_r;
   hps_pkg::hps_state_t s_nxt;
   hps_pkg::hps_hist_t hist [`HPS_HIST_DEPTH];
   hps_pkg::hps_hist_t hist_wr;
   hps_pkg::hps_hist_t hist_old;
   hps_pkg::hps_hist_t hist_first;
   hps_pkg::hps_pix_t push_pix;
   logic hist_we;
   logic push;
   logic fifo_ready;
   logic [2:0] fifo_cnt;

   // address decode: {hit, select}
   function automatic logic [2:0] reg_dec(input logic [31:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a == `HPS_ADDR(`HPS_IDX_RATIO)) begin
         r = 3'h4;
      end else if (a == `HPS_ADDR(`HPS_IDX_ACL)) begin
         r = 3'h5;
      end else if (a == `HPS_ADDR(`HPS_IDX_GCTL)) begin
         r = 3'h6;
      end else if (a == `HPS_ADDR(`HPS_IDX_STAT)) begin
         r = 3'h7;
      end
      return r;
   endfunction

   // prefilter, normalised to unity gain by a final divide by 32
   function automatic logic [7:0] fir(input logic [1:0] sel,
                                      input logic [6:0][7:0] t,
                                      input logic luma);
      logic signed [15:0] x [7];
      logic signed [15:0] acc;
      for (int i = 0; i < 7; i++) begin
         x[i] = $signed({8'h00, t[i]});
      end
      case (hps_pkg::hps_pf_t'(sel))
         hps_pkg::HPS_PF_121: begin
            acc = (x[2] + 16'sd2 * x[3] + x[4]) * 16'sd8; // RULE_10
         end
         hps_pkg::HPS_PF_12221: begin
            acc = (x[1] + 16'sd2 * (x[2] + x[3] + x[4]) + x[5])
                  * 16'sd4; // RULE_10
         end
         hps_pkg::HPS_PF_WIDE: begin
            if (luma) begin
               // quarter-step taps scaled by four to stay integer
               acc = 16'sd4 * (x[1] + x[5] - x[0] - x[6])
                     + 16'sd7 * (x[2] + x[4]) + 16'sd18 * x[3]; // RULE_10
            end else begin
               acc = 16'sd3 * (x[1] + x[5]) + 16'sd8 * (x[2] + x[4])
                     + 16'sd10 * x[3]; // RULE_10
            end
         end
         default: begin
            acc = x[3] * 16'sd32; // RULE_10
         end
      endcase
      acc = (acc + 16'sd16) >>> 5;
      if (acc < 16'sd0) begin
         return 8'h00;
      end else if (acc > 16'sd255) begin
         return 8'hFF;
      end
      return acc[7:0];
   endfunction

   // weighted window sum from prefix sums and the two end samples
   function automatic logic [15:0] win_sum(input logic [15:0] pnow,
                                           input logic [15:0] pold,
                                           input logic [7:0] newest,
                                           input logic [7:0] oldest,
                                           input logic dbl);
      logic [15:0] sum;
      sum = pnow - pold;
      if (dbl) begin
         // ends once, inner twice: gain 2*length  // RULE_15
         sum = (sum << 1) - {8'h00, newest} - {8'h00, oldest};
      end
      return sum; // RULE_02
   endfunction

   // power-of-two renormalisation, clipped to eight bits
   function automatic logic [7:0] renorm(input logic [15:0] v,
                                         input logic [2:0] sh);
      logic [15:0] t;
      t = v >> sh; // RULE_03
      // clip guards against settings whose gain exceeds one
      return (t > 16'h00FF) ? 8'hFF : t[7:0];
   endfunction

   hps_fifo #(
      .W($bits(hps_pkg::hps_pix_t)),
      .D(`HPS_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_data_i(push_pix),
      .in_ready_o(fifo_ready),
      .out_valid_o(out_valid_o),
      .out_data_o(out_pix_o),
      .out_ready_i(out_ready_i),
      .count_o(fifo_cnt)
   );

   // a full fifo stalls the source; no sample is ever dropped
   assign in_ready_o = fifo_ready;
   assign hrdata_o = s_r.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always_comb begin
      logic [2:0] dec;
      logic take;
      logic [6:0][7:0] ty;
      logic [6:0][7:0] tc;
      logic [7:0] fy;
      logic [7:0] fc;
      logic [15:0] py;
      logic [15:0] pc;
      logic [7:0] oy;
      logic [7:0] oc;
      logic [5:0] cnt;
      logic done;
      logic dbl;
      logic [7:0] raw_y;
      logic [7:0] raw_c;
      dec = 3'h0;
      take = 1'b0;
      ty = s_r.taps_y;
      tc = s_r.taps_c;
      fy = 8'h00;
      fc = 8'h00;
      py = s_r.psum_y;
      pc = s_r.psum_c;
      oy = 8'h00;
      oc = 8'h00;
      cnt = s_r.grp_cnt;
      done = 1'b0;
      dbl = s_r.gctl[`HPS_GCTL_DBL];
      raw_y = s_r.first_y;
      raw_c = s_r.first_c;
      s_nxt = s_r;
      hist_we = 1'b0;
      hist_wr = '0;
      push = 1'b0;
      push_pix = '0;

      // data phase of a write: store before any read sees it
      s_nxt.wr_pend = 1'b0;
      if (s_r.wr_pend) begin
         case (s_r.wr_sel)
            2'h0: begin
               s_nxt.ratio = hwdata_i[`HPS_RATIO_F]; // RULE_16
            end
            2'h1: begin
               s_nxt.acl = hwdata_i[`HPS_ACL_F]; // RULE_17
            end
            2'h2: begin
               s_nxt.gctl = hwdata_i[7:0]; // RULE_11
            end
            default: begin
            end
         endcase
      end

      // address phase; read data is latched now from the updated view
      if (hsel_i && htrans_i[1] && hready_i) begin
         dec = reg_dec(haddr_i);
         s_nxt.wr_pend = hwrite_i && dec[2];
         s_nxt.wr_sel = dec[1:0];
         if (!hwrite_i) begin
            case (dec)
               3'h4: s_nxt.rdata = {26'h0, s_nxt.ratio};
               3'h5: s_nxt.rdata = {26'h0, s_nxt.acl};
               3'h6: s_nxt.rdata = {24'h0, s_nxt.gctl};
               3'h7: s_nxt.rdata = {27'h0, fifo_cnt, s_r.first_pend,
                                    s_r.in_line};
               default: s_nxt.rdata = 32'h0;
            endcase
         end
      end

      take = in_valid_i && fifo_ready;
      if (take) begin
         // edge replication at line start so old-line taps never leak
         if (in_pix_i.sol) begin
            ty = {7{in_pix_i.y}};
            tc = {7{in_pix_i.c}};
         end else begin
            ty = {s_r.taps_y[5:0], in_pix_i.y};
            tc = {s_r.taps_c[5:0], in_pix_i.c};
         end
         s_nxt.taps_y = ty;
         s_nxt.taps_c = tc;
         fy = fir(s_r.gctl[`HPS_GCTL_LPF], ty, 1'b1); // RULE_08
         fc = fir(s_r.gctl[`HPS_GCTL_CPF], tc, 1'b0); // RULE_08
         py = s_r.psum_y + {8'h00, fy};
         pc = s_r.psum_c + {8'h00, fc};
         s_nxt.psum_y = py;
         s_nxt.psum_c = pc;
         hist_we = 1'b1;
         hist_wr = '{psum_y: py, psum_c: pc, fy: fy, fc: fc};
         s_nxt.wptr = s_r.wptr + 7'h01;

         // window of acl+1 samples; history covers the deepest one
         if (s_r.acl == 6'h00) begin
            oy = renorm(win_sum(py, s_r.psum_y, fy, fy, dbl),
                        s_r.gctl[`HPS_GCTL_SH]); // RULE_17
            oc = renorm(win_sum(pc, s_r.psum_c, fc, fc, dbl),
                        s_r.gctl[`HPS_GCTL_SH]);
         end else begin
            oy = renorm(win_sum(py, hist_old.psum_y, fy, hist_first.fy, dbl),
                        s_r.gctl[`HPS_GCTL_SH]); // RULE_17
            oc = renorm(win_sum(pc, hist_old.psum_c, fc, hist_first.fc, dbl),
                        s_r.gctl[`HPS_GCTL_SH]);
         end

         // one group counter serves both paths
         cnt = in_pix_i.sol ? 6'h00 : s_r.grp_cnt;
         done = (cnt == s_r.ratio - 6'h01); // RULE_01
         s_nxt.grp_cnt = done ? 6'h00 : cnt + 6'h01; // RULE_16
         if (in_pix_i.sol) begin
            s_nxt.first_y = in_pix_i.y;
            s_nxt.first_c = in_pix_i.c;
            s_nxt.first_pend = 1'b1;
            s_nxt.in_line = 1'b1;
            raw_y = in_pix_i.y;
            raw_c = in_pix_i.c;
         end

         if (in_pix_i.eol) begin
            // fade-out: last sample passes through untouched
            push = 1'b1; // RULE_09
            push_pix = '{sol: s_nxt.first_pend, eol: 1'b1,
                         y: in_pix_i.y, c: in_pix_i.c};
            s_nxt.first_pend = 1'b0;
            s_nxt.in_line = 1'b0;
         end else if (done) begin
            push = 1'b1; // RULE_18
            if (s_nxt.first_pend) begin
               // fade-in: first output is the line's first raw sample
               push_pix = '{sol: 1'b1, eol: 1'b0,
                            y: raw_y, c: raw_c}; // RULE_09
               s_nxt.first_pend = 1'b0;
            end else begin
               push_pix = '{sol: 1'b0, eol: 1'b0, y: oy, c: oc}; // RULE_18
            end
         end
      end
   end

   // prefix entry just before the window, and the window's oldest sample
   assign hist_old = hist[s_r.wptr - {1'b0, s_r.acl} - 7'h01]; // RULE_06
   assign hist_first = hist[s_r.wptr - {1'b0, s_r.acl}];

   // history memory carries no reset; prefix differences are wrap-safe
   always_ff @(posedge sys_clk_i) begin
      if (hist_we) begin
         hist[s_r.wptr] <= hist_wr;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.ratio <= `HPS_RST_RATIO;
         s_r.acl <= `HPS_RST_ACL;
         s_r.gctl <= `HPS_RST_GCTL;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// *** verification/hps_prescaler_props.sv ***
module hps_prescaler_props (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // streams
   input wire logic in_valid_i,
   input wire logic in_ready_o,
   input wire logic out_valid_o,
   input wire hps_pkg::hps_pix_t out_pix_o,
   input wire logic out_ready_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_take;
   logic await_sol_r;
   assign rd_take = hsel_i & htrans_i[1] & ~hwrite_i & hready_i;
   // line framing seen at the sink: after eol the next word opens a line
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         await_sol_r <= 1'b1;
      end else if (out_valid_o & out_ready_i) begin
         await_sol_r <= out_pix_o.eol;
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   AST_OKAY: assert property (hresp_o == 1'b0)
      else $error("bus response not okay");
   AST_ZWS: assert property (hreadyout_o == 1'b1)
      else $error("bus wait state inserted");
   AST_UNMAP: assert property (rd_take && haddr_i == 32'h0 |=>
      hrdata_o == 32'h0) else $error("unmapped read not zero");
   AST_UPPER: assert property (rd_take |=> hrdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_STBL: assert property (!rd_take |=> $stable(hrdata_o))
      else $error("read data changed without read");
   AST_RST: assert property ($fell(rst_i) |->
      !out_valid_o && in_ready_o) else $error("stream not idle after reset");
   AST_HOLD: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable(out_pix_o)) else $error("output not held");
   AST_ROSE: assert property ($rose(out_valid_o) |->
      $past(in_valid_i) && $past(in_ready_o))
      else $error("output from nowhere");
   AST_FULL: assert property (!in_ready_o |-> out_valid_o)
      else $error("refusing with empty buffer");
   AST_SOL: assert property (out_valid_o |->
      out_pix_o.sol == await_sol_r) else $error("line start marker misplaced");
endmodule

bind hps_prescaler hps_prescaler_props u_hps_prescaler_props (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
   .out_valid_o(out_valid_o), .out_pix_o(out_pix_o),
   .out_ready_i(out_ready_i));

// *** verification/hps_sink.sv ***
module hps_sink (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // pacing: 0 prompt, 1 random stalls, 2 stalled
   input wire logic [1:0] mode_i,
   // downstream ready
   output logic ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lfsr_r;
   // ready is registered, as the fine scaler pulls on its own clock edge
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lfsr_r <= 8'hA5;
         ready_o <= 1'b0;
      end else begin
         lfsr_r <= {lfsr_r[6:0],
                    lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         ready_o <= (mode_i == 2'h0) | ((mode_i == 2'h1) & lfsr_r[0]);
      end
   end
endmodule

// *** verification/test_horizontal_prescaler_fir.sv ***
`include "hps_map.svh"

module test_horizontal_prescaler_fir;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, in_valid, in_ready;
   logic out_valid, out_ready;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [1:0] htrans, mode;
   hps_pkg::hps_pix_t in_pix, out_pix;
   hps_pkg::hps_pix_t exp_q[$];
   int err_count, num_checks, ratio, acl, dbl, sh;
   int ly[$];
   int lc[$];

   hps_prescaler u_hps_prescaler (.sys_clk_i(sys_clk), .rst_i(rst),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hready_i(hreadyout), .hwdata_i(hwdata),
      .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .in_valid_i(in_valid), .in_pix_i(in_pix), .in_ready_o(in_ready),
      .out_valid_o(out_valid), .out_pix_o(out_pix), .out_ready_i(out_ready));
   hps_sink u_hps_sink (.sys_clk_i(sys_clk), .rst_i(rst), .mode_i(mode),
      .ready_o(out_ready));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic give_verdict();
      if (err_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic give_up();
      err_count++;
      $display("BAD %0t wait ran out", $time);
      give_verdict();
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one single ahb transfer; waits on hready in both phases
   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      r = hrdata;
      if (n >= 50) give_up();
   endtask

   // offers one sample and queues what the model expects from it
   task automatic put(input logic [7:0] y, input logic [7:0] c,
                      input logic s, input logic e);
      int n, k, w, sy, sc, m;
      logic r;
      in_pix <= {s, e, y, c};
      in_valid <= 1'b1;
      n = 0;
      do begin
         @(negedge sys_clk);
         r = in_ready;
         n++;
         @(posedge sys_clk);
      end while (r !== 1'b1 && n < 1000);
      if (n >= 1000) give_up();
      if (s) begin ly.delete(); lc.delete(); end
      ly.push_back(y);
      lc.push_back(c);
      k = ly.size() - 1;
      if (e) exp_q.push_back({1'b0, 1'b1, y, c});
      else if ((k + 1) % ratio == 0 && k + 1 == ratio)
         exp_q.push_back({1'b1, 1'b0, 8'(ly[0]), 8'(lc[0])});
      else if ((k + 1) % ratio == 0) begin
         sy = 0;
         sc = 0;
         for (int j = 0; j <= acl; j++) begin
            w = (dbl != 0 && j != 0 && j != acl) ? 2 : 1;
            // every select delays the centre tap three samples; sol fills
            m = (k - j < 3) ? 0 : k - j - 3;
            sy += w * ly[m];
            sc += w * lc[m];
         end
         sy = (sy >> sh) > 255 ? 255 : sy >> sh;
         sc = (sc >> sh) > 255 ? 255 : sc >> sh;
         exp_q.push_back({1'b0, 1'b0, 8'(sy), 8'(sc)});
      end
   endtask

   task automatic send_line(input int n, input logic cst);
      logic [31:0] v;
      v = rnd();
      for (int i = 0; i < n; i++) begin
         if (!cst) v = rnd();
         put(v[7:0], v[15:8], i == 0, i == n - 1);
      end
      in_valid <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 5000) begin @(posedge sys_clk); n++; end
      if (n >= 5000) give_up();
      @(negedge sys_clk);
      chk(32'(out_valid), 32'h0);
      @(posedge sys_clk);
   endtask

   // software settings; pf holds chroma select above luma select
   task automatic setup(input int r, a, d, s, input logic [3:0] pf);
      logic [31:0] v, rd;
      ratio = r;
      acl = a;
      dbl = d;
      sh = s;
      bus(`HPS_ADDR(`HPS_IDX_RATIO), 1'b1, {26'h3FFFFFF, 6'(r)}, rd);
      bus(`HPS_ADDR(`HPS_IDX_RATIO), 1'b0, 32'h0, rd);
      chk(rd, 32'(r));
      bus(`HPS_ADDR(`HPS_IDX_ACL), 1'b1, 32'(a), rd);
      v = {24'h0, pf, 1'(d), 3'(s)};
      bus(`HPS_ADDR(`HPS_IDX_GCTL), 1'b1, v, rd);
      bus(`HPS_ADDR(`HPS_IDX_GCTL), 1'b0, 32'h0, rd);
      chk(rd, v);
   endtask

   always @(posedge sys_clk) begin
      if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0);
         else chk({14'h0, out_pix}, {14'h0, exp_q.pop_front()});
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      logic [31:0] rd;
      int r, a, d, s, pf, g;
      {hsel, hwrite, in_valid, htrans, mode} = '0;
      {haddr, hwdata, in_pix} = '0;
      {err_count, num_checks} = '0;
      seed = 32'h4A1E;
      rst = 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      bus(`HPS_ADDR(`HPS_IDX_RATIO), 1'b0, 32'h0, rd);
      chk(rd, 32'h1);
      bus(`HPS_ADDR(`HPS_IDX_ACL), 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      bus(`HPS_ADDR(`HPS_IDX_GCTL), 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      bus(32'h0, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      // stalled sink: four ratio-1 outputs fill the buffer
      mode <= 2'h2;
      setup(1, 0, 0, 0, 4'h0);
      for (int i = 0; i < 4; i++) put(8'(i * 9), 8'(i * 7), i == 0, 1'b0);
      @(negedge sys_clk);
      chk(32'(in_ready), 32'h0);
      @(posedge sys_clk);
      // status: four words buffered, inside a line, first output gone
      bus(`HPS_ADDR(`HPS_IDX_STAT), 1'b0, 32'h0, rd);
      chk(rd, 32'h11);
      mode <= 2'h1;
      put(8'hFF, 8'h00, 1'b0, 1'b1);
      in_valid <= 1'b0;
      drain();
      for (int it = 0; it < 12; it++) begin
         r = (it == 0) ? 63 : 1 + rnd() % 8;
         a = (it == 0) ? 63 : rnd() % (2 * r);
         d = (a == 0) ? 0 : rnd() % 2;
         // shift must cover the gain so overall gain stays at most one
         g = (d + 1) * a + 1 - d;
         s = 0;
         while ((1 << s) < g) s++;
         s = s + rnd() % (8 - s);
         if (it == 1 || it == 2) begin
            // advisory sets: power-of-two gain, shifter alone renormalises
            r = 2 * it;
            a = (it == 1) ? 2 : 7;
            d = (it == 1) ? 1 : 0;
            s = it + 1;
         end
         pf = (it >= 8) ? it * 5 : 0;
         mode <= 2'(it % 2);
         setup(r, a, d, s, 4'(pf));
         send_line(2 * r + 1 + rnd() % (r + 1), pf != 0);
         send_line(2 * r + 1 + rnd() % (r + 1), pf != 0);
         drain();
      end
      give_verdict();
   end
endmodule
